// *** rtl/dcs_pkg.sv ***
// dcs_pkg: constants and carriers for the data compare status recorder.
// assumes one completing instruction record per sys_clk from the pipeline.
package dcs_pkg;
   // ==================================================================
   // register map, byte addresses
   localparam logic [7:0] DCS_OFF_STATUS = 8'h00;
   localparam logic [7:0] DCS_OFF_RETDBG = 8'h04;
   localparam logic [7:0] DCS_OFF_RETCRIT = 8'h08;
   localparam logic [7:0] DCS_OFF_SYND = 8'h0c;
   localparam logic [7:0] DCS_OFF_MMUA = 8'h10;
   localparam logic [7:0] DCS_OFF_CTRL = 8'h14;
   // ==================================================================
   // status layout
   localparam int DCS_ST_DAC_LO = 0;
   localparam int DCS_ST_DAC_HI = 1;
   localparam int DCS_ST_IDE = 2;
   localparam int DCS_ST_OFS_LO = 4;
   localparam int DCS_ST_OFS_HI = 6;
   // control layout
   localparam int DCS_CT_DBGSET = 0;
   localparam int DCS_CT_DBGIRQ = 1;
   localparam logic [1:0] DCS_CTRL_RST = 2'h3;
   // ==================================================================
   // syndrome causes and offset range
   localparam logic [1:0] DCS_SYND_NONE = 2'h0;
   localparam logic [1:0] DCS_SYND_TLB = 2'h1;
   localparam logic [1:0] DCS_SYND_STOR = 2'h2;
   localparam logic [2:0] DCS_OFS_ZERO = 3'h0;
   localparam logic [2:0] DCS_OFS_ONE = 3'h1;
   localparam logic [2:0] DCS_OFS_MAX = 3'h5;
   localparam logic [31:0] DCS_WORD_ZERO = 32'h0;
   localparam logic [1:0] DCS_HTRANS_NONSEQ = 2'h2;

   // one completing instruction from the pipeline
   typedef struct packed {
      logic valid;
      logic isLdSt;
      logic isMultiple;
      logic [1:0] dacHit;
      logic dvcHit;
      logic tlbMiss;
      logic storFault;
      logic instFault;
      logic dualIssued;
      logic [31:0] addr;
      logic [31:0] nextAddr;
   } dcs_insn_t;

   // actions reported back to the pipeline
   typedef struct packed {
      logic tlbTake;
      logic storTake;
      logic debugTake;
      logic syndUpdate;
      logic mmuUpdate;
      logic excMask;
      logic ctrUpdate;
      logic issueStop;
   } dcs_act_t;

   typedef enum logic [1:0] {DCS_IDLE, DCS_WAIT2, DCS_WAIT3} dcs_state_t;
endpackage

// *** rtl/dcs_status_update.sv ***
// dcs_status_update: records data compare debug events, delayed value
// compare reports, and the syndrome and mmu assist updates.
// assumes pipeline logic on sys_clk and a single ahb-lite master.
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/100ps

module dcs_status_update
   import dcs_pkg::*;
(
   input wire logic sys_clk, // core clock
   input wire logic rstn, // synchronous reset
   input wire dcs_pkg::dcs_insn_t insn, // completing instruction
   output dcs_pkg::dcs_act_t act, // actions to pipeline
   output logic debugIrq, // debug interrupt request level
   input wire logic hsel, // ahb select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb ready in
   output logic hreadyout, // ahb ready out
   output logic hresp, // ahb response
   output logic [31:0] hrdata // ahb read data
);
   import dcs_pkg::*;

   // ==================================================================
   // state
   dcs_state_t state_r, state_nxt;
   logic [1:0] dacBits_r, dacBits_nxt;
   logic [2:0] offCnt_r, offCnt_nxt;
   logic [1:0] stDac_r;
   logic stIde_r;
   logic [2:0] completed_offset_field;
   logic [31:0] debug_return_address;
   logic [31:0] critical_return_address;
   logic [1:0] exception_syndrome_reg;
   logic [31:0] mmu_assist_regs;
   logic [1:0] ctrl_r;
   // record request from the sequencer
   logic rec;
   logic recIde;
   logic [1:0] recBits;
   logic [2:0] recOfs;
   logic [31:0] recAddr;
   dcs_act_t actC;

   // saturating add of completed instructions
   function automatic logic [2:0] addDone(input logic [2:0] base,
                                          input logic dual);
      logic [3:0] sum;
      sum = {1'b0, base} + 4'h1 + {3'h0, dual};
      if (sum > {1'b0, DCS_OFS_MAX}) begin
         addDone = DCS_OFS_MAX;
      end else begin
         addDone = sum[2:0];
      end
   endfunction

   // ==================================================================
   // sequencer
   always_comb begin
      state_nxt = state_r;
      dacBits_nxt = dacBits_r;
      offCnt_nxt = offCnt_r;
      rec = 1'b0;
      recIde = 1'b0;
      recBits = dacBits_r;
      recOfs = DCS_OFS_ZERO;
      recAddr = insn.addr;
      actC = '0;
      actC.ctrUpdate = insn.valid;
      if (insn.valid) begin
         unique case (state_r)
            DCS_IDLE: begin
               if (insn.isLdSt && (insn.tlbMiss || insn.storFault)) begin
                  if (insn.dacHit == 2'h0) begin
                     actC.tlbTake = insn.tlbMiss;
                     actC.mmuUpdate = insn.tlbMiss;
                     actC.storTake = !insn.tlbMiss;
                     actC.syndUpdate = 1'b1;
                  end else begin
                     rec = 1'b1;
                     recIde = 1'b1;
                     recBits = insn.dacHit;
                     actC.excMask = 1'b1;
                  end
               end else if (insn.isLdSt && insn.dacHit != 2'h0) begin
                  if (insn.dvcHit) begin
                     state_nxt = DCS_WAIT2;
                     dacBits_nxt = insn.dacHit;
                     offCnt_nxt = {2'h0, insn.dualIssued};
                  end else begin
                     rec = 1'b1;
                     recBits = insn.dacHit;
                     recAddr = insn.nextAddr;
                  end
               end
            end
            DCS_WAIT2: begin
               if (insn.instFault) begin
                  rec = 1'b1;
                  recOfs = offCnt_r;
                  actC.excMask = 1'b1;
                  actC.issueStop = 1'b1;
                  actC.ctrUpdate = 1'b0;
               end else if (insn.isLdSt &&
                            (insn.tlbMiss || insn.storFault)) begin
                  rec = 1'b1;
                  recOfs = offCnt_r;
                  actC.excMask = 1'b1;
                  actC.ctrUpdate = 1'b0;
               end else if (insn.isLdSt && insn.dacHit != 2'h0 &&
                            (!insn.dvcHit || insn.isMultiple)) begin
                  rec = 1'b1;
                  recBits = dacBits_r | insn.dacHit;
                  recOfs = addDone(offCnt_r, insn.dualIssued);
                  recAddr = insn.nextAddr;
               end else begin
                  state_nxt = DCS_WAIT3;
                  offCnt_nxt = addDone(offCnt_r, insn.dualIssued);
                  if (insn.isLdSt) begin
                     dacBits_nxt = dacBits_r | insn.dacHit;
                  end
               end
            end
            DCS_WAIT3: begin
               state_nxt = DCS_IDLE;
               recOfs = offCnt_r;
               rec = 1'b1;
               if (insn.instFault) begin
                  actC.excMask = 1'b1;
                  actC.issueStop = 1'b1;
                  actC.ctrUpdate = 1'b0;
               end else if (!insn.isLdSt) begin
                  recOfs = offCnt_r;
               end else if (insn.tlbMiss || insn.storFault) begin
                  actC.excMask = 1'b1;
                  actC.ctrUpdate = 1'b0;
               end else begin
                  recBits = dacBits_r | insn.dacHit;
                  recOfs = addDone(offCnt_r, insn.dualIssued);
                  recAddr = insn.nextAddr;
               end
            end
         endcase
      end
      if (rec) begin
         state_nxt = DCS_IDLE;
         actC.debugTake = 1'b1;
         if (!ctrl_r[DCS_CT_DBGIRQ]) begin
            recIde = 1'b1;
         end
      end
   end

   assign act = actC;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state_r <= DCS_IDLE;
         dacBits_r <= 2'h0;
         offCnt_r <= DCS_OFS_ZERO;
      end else begin
         state_r <= state_nxt;
         dacBits_r <= dacBits_nxt;
         offCnt_r <= offCnt_nxt;
      end
   end

   // ==================================================================
   // bus slave, zero wait, always okay
   logic wrPend_r;
   logic [7:0] wrAddr_r;
   logic addrPhase;
   logic [31:0] rdWord;
   logic [31:0] statusWord;
   logic stWrite;

   assign addrPhase = hsel && hready && htrans == DCS_HTRANS_NONSEQ;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign stWrite = wrPend_r && wrAddr_r == DCS_OFF_STATUS;

   always_comb begin
      statusWord = DCS_WORD_ZERO;
      statusWord[DCS_ST_DAC_HI:DCS_ST_DAC_LO] = stDac_r;
      statusWord[DCS_ST_IDE] = stIde_r;
      statusWord[DCS_ST_OFS_HI:DCS_ST_OFS_LO] = completed_offset_field;
      unique case (haddr[7:0])
         DCS_OFF_STATUS: rdWord = statusWord;
         DCS_OFF_RETDBG: rdWord = debug_return_address;
         DCS_OFF_RETCRIT: rdWord = critical_return_address;
         DCS_OFF_SYND: rdWord = {30'h0, exception_syndrome_reg};
         DCS_OFF_MMUA: rdWord = mmu_assist_regs;
         DCS_OFF_CTRL: rdWord = {30'h0, ctrl_r};
         default: rdWord = DCS_WORD_ZERO;
      endcase
      if (haddr[31:8] != 24'h0) begin
         rdWord = DCS_WORD_ZERO;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h0;
         hrdata <= DCS_WORD_ZERO;
      end else begin
         wrPend_r <= addrPhase && hwrite && haddr[31:8] == 24'h0;
         wrAddr_r <= haddr[7:0];
         if (addrPhase && !hwrite) begin
            hrdata <= rdWord;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ctrl_r <= DCS_CTRL_RST;
      end else if (wrPend_r && wrAddr_r == DCS_OFF_CTRL) begin
         ctrl_r <= hwdata[1:0];
      end
   end

   // ==================================================================
   // debug status, write one to clear (offset field by a one in its top bit), new record wins
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         stDac_r <= 2'h0;
         stIde_r <= 1'b0;
         completed_offset_field <= DCS_OFS_ZERO;
      end else begin
         stDac_r <= (stDac_r & ~({2{stWrite}} &
                    hwdata[DCS_ST_DAC_HI:DCS_ST_DAC_LO])) |
                    ({2{rec}} & recBits);
         stIde_r <= (stIde_r && !(stWrite && hwdata[DCS_ST_IDE])) ||
                    (rec && recIde);
         if (rec) begin
            completed_offset_field <= recOfs;
         end else if (stWrite && hwdata[DCS_ST_OFS_HI]) begin
            completed_offset_field <= DCS_OFS_ZERO;
         end
      end
   end

   assign debugIrq = ctrl_r[DCS_CT_DBGIRQ] && stDac_r != 2'h0;

   // ==================================================================
   // saved return address, syndrome, mmu assist
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         debug_return_address <= DCS_WORD_ZERO;
         critical_return_address <= DCS_WORD_ZERO;
      end else if (rec && ctrl_r[DCS_CT_DBGSET]) begin
         debug_return_address <= recAddr;
      end else if (rec) begin
         critical_return_address <= recAddr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         exception_syndrome_reg <= DCS_SYND_NONE;
         mmu_assist_regs <= DCS_WORD_ZERO;
      end else begin
         if (actC.syndUpdate) begin
            exception_syndrome_reg <= actC.tlbTake ? DCS_SYND_TLB :
                                      DCS_SYND_STOR;
         end
         if (actC.mmuUpdate) begin
            mmu_assist_regs <= insn.addr;
         end
      end
   end

   // ==================================================================
   // checks
   sequence s_first_plain;
      insn.valid && state_r == DCS_IDLE && insn.isLdSt &&
      !insn.tlbMiss && !insn.storFault && insn.dacHit != 2'h0 &&
      !insn.dvcHit;
   endsequence
   sequence s_first_value;
      insn.valid && state_r == DCS_IDLE && insn.isLdSt &&
      !insn.tlbMiss && !insn.storFault && insn.dacHit != 2'h0 &&
      insn.dvcHit && !insn.dualIssued;
   endsequence
   sequence s_clean_next;
      insn.valid && !insn.instFault && !insn.isLdSt && !insn.dualIssued;
   endsequence

   a_tlb_syndrome: assert property (@(posedge sys_clk) disable iff (!rstn)
      act.tlbTake |=> exception_syndrome_reg == DCS_SYND_TLB &&
      $stable(stDac_r)) else $error("tlb take left status wrong");
   a_stor_no_mmu: assert property (@(posedge sys_clk) disable iff (!rstn)
      act.storTake |-> !act.mmuUpdate && !act.debugTake)
      else $error("storage take touched mmu or debug");
   a_fault_dac_ide: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state_r == DCS_IDLE && insn.valid && insn.isLdSt && insn.tlbMiss &&
      insn.dacHit != 2'h0) |-> !act.syndUpdate ##1 stIde_r)
      else $error("fault with compare not imprecise");
   a_plain_offset: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_first_plain |=> completed_offset_field == DCS_OFS_ZERO)
      else $error("plain compare offset not zero");
   a_value_delay: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_first_value ##1 s_clean_next ##1 s_clean_next |=>
      completed_offset_field == DCS_OFS_ONE)
      else $error("delayed value report offset wrong");
   a_value_nodebug: assert property (@(posedge sys_clk) disable iff (!rstn)
      s_first_value |-> !act.debugTake ##1 state_r == DCS_WAIT2)
      else $error("value hit reported too early");
   a_second_mask: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state_r == DCS_WAIT2 && insn.valid && insn.isLdSt &&
      !insn.instFault && insn.storFault) |-> act.excMask &&
      !act.ctrUpdate && !act.syndUpdate)
      else $error("second fault not masked");
   a_inst_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
      (state_r != DCS_IDLE && insn.valid && insn.instFault) |->
      act.issueStop && act.debugTake)
      else $error("instruction fault did not stop");
   a_off_range: assert property (@(posedge sys_clk) disable iff (!rstn)
      completed_offset_field <= DCS_OFS_MAX)
      else $error("offset beyond five");
   a_crit_pair: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rec && !ctrl_r[DCS_CT_DBGSET]) |=> $stable(debug_return_address))
      else $error("debug pair written while disabled");
endmodule

// *** test/dcs_pipe_model.sv ***
// dcs_pipe_model: stands in for the load/store unit and mmu logic,
// handing the recorder one completing instruction record per call.
// assumes the recorder answers combinationally within the cycle.
`timescale 1ns/100ps
module dcs_pipe_model (
   input wire logic sys_clk, // core clock
   output dcs_pkg::dcs_insn_t insn, // completing instruction
   input wire dcs_pkg::dcs_act_t act // recorder actions
);
   import dcs_pkg::*;

   // ==================================================================
   // idle record
   initial insn = '0;

   // released record: invalid, payload inverted so stale data never lines up
   task automatic idle();
      dcs_insn_t q;
      @(posedge sys_clk);
      q = ~insn;
      q.valid = 1'b0;
      insn <= q;
   endtask

   // ==================================================================
   // one instruction, after gap idle cycles; act taken mid-cycle
   task automatic issue(input dcs_insn_t i, input int gap,
                        output dcs_act_t a);
      for (int g = 0; g < gap; g++) idle();
      @(posedge sys_clk);
      insn <= i;
      @(negedge sys_clk);
      a = act;
   endtask
endmodule

// *** test/dcs_status_update_bench.sv ***
// dcs_status_update_bench: row-driven check of status, offset, return,
// syndrome and mmu assist recording, then register bus corner cases.
// assumes hreadyout feeds hready and the pipeline model drives insn.
`timescale 1ns/100ps
module dcs_status_update_bench;
   import dcs_pkg::*;

   // ==================================================================
   // instruction codes: ldst mult dac2 dac1 dvc tlb stor ifault dual
   localparam logic [8:0] AL = 9'h000, LS = 9'h100, MUL = 9'h080;
   localparam logic [8:0] D2 = 9'h040, D1 = 9'h020, DV = 9'h010;
   localparam logic [8:0] TL = 9'h008, SF = 9'h004, IFL = 9'h002;
   localparam logic [8:0] DU = 9'h001, V1 = 9'h130;

   typedef struct {
      int n;
      logic [8:0] op [3];
      logic [7:0] st;
      logic [7:0] ro;
      logic [7:0] act;
      logic [7:0] msk;
   } dcs_row_t;

   // act bits: tlb stor dbg synd mmu mask ctr stop; ro ff keeps return
   dcs_row_t rows [19] = '{
      '{1, '{LS|TL, AL, AL}, 8'h00, 8'hff, 8'h98, 8'hf8},
      '{1, '{LS|SF, AL, AL}, 8'h00, 8'hff, 8'h50, 8'hf8},
      '{1, '{LS|TL|D1, AL, AL}, 8'h05, 8'h00, 8'h20, 8'hf8},
      '{1, '{LS|SF|D2, AL, AL}, 8'h06, 8'h00, 8'h20, 8'hf8},
      '{1, '{LS|D1, AL, AL}, 8'h01, 8'h04, 8'h20, 8'hf8},
      '{3, '{V1, AL, AL}, 8'h11, 8'h08, 8'h20, 8'hf8},
      '{3, '{V1, AL, LS}, 8'h21, 8'h0c, 8'h22, 8'hfa},
      '{2, '{V1, LS|TL, AL}, 8'h01, 8'h04, 8'h24, 8'hfe},
      '{2, '{V1, LS|SF|D2, AL}, 8'h01, 8'h04, 8'h24, 8'hfe},
      '{2, '{V1, LS|D2, AL}, 8'h13, 8'h08, 8'h20, 8'hf8},
      '{3, '{V1, LS|D2|DV, LS}, 8'h23, 8'h0c, 8'h22, 8'hfa},
      '{3, '{V1, LS|D2|DV, LS|TL}, 8'h13, 8'h08, 8'h24, 8'hfe},
      '{2, '{V1, LS|MUL|D2|DV, LS}, 8'h13, 8'h08, 8'h20, 8'hf8},
      '{3, '{V1, AL, LS|SF}, 8'h11, 8'h08, 8'h24, 8'hfe},
      '{3, '{V1, AL, LS|D2}, 8'h23, 8'h0c, 8'h22, 8'hfa},
      '{3, '{V1, AL, LS|D1}, 8'h21, 8'h0c, 8'h22, 8'hfa},
      '{3, '{V1|DU, AL, AL}, 8'h21, 8'h08, 8'h20, 8'hf8},
      '{3, '{V1|DU, AL|DU, LS|DU}, 8'h51, 8'h10, 8'h20, 8'hf8},
      '{2, '{V1, AL|IFL, AL}, 8'h01, 8'h04, 8'h25, 8'hff}
   };

   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   dcs_insn_t insn;
   dcs_act_t act;
   logic debugIrq, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int error_cnt = 0;
   int check_count = 0;

   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   assign hready = hreadyout;
   always #12.5 sys_clk = ~sys_clk;

   dcs_status_update dcs_status_update_inst (.sys_clk(sys_clk), .rstn(rstn),
      .insn(insn), .act(act), .debugIrq(debugIrq), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata));
   dcs_pipe_model dcs_pipe_model_inst (.sys_clk(sys_clk), .insn(insn),
      .act(act));

   // ==================================================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, ad};
      htrans <= DCS_HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic rdc(input logic [7:0] ad, input logic [31:0] e,
                      input string nm);
      logic [31:0] v;
      xfer(1'b0, ad, 32'h0, v);
      chk(nm, e, v);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] v;
      xfer(1'b1, ad, d, v);
   endtask

   task automatic irq(input logic e);
      @(negedge sys_clk);
      chk("debugIrq", {31'h0, e}, {31'h0, debugIrq});
   endtask

   function automatic dcs_insn_t mk(input logic [8:0] f,
                                    input logic [31:0] a);
      dcs_insn_t i;
      i = '0;
      {i.isLdSt, i.isMultiple, i.dacHit, i.dvcHit, i.tlbMiss, i.storFault,
       i.instFault, i.dualIssued} = f;
      i.valid = 1'b1;
      i.addr = a;
      i.nextAddr = a + (f[0] ? 32'h8 : 32'h4);
      return i;
   endfunction

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end

   // ==================================================================
   // main sequence
   initial begin
      logic [31:0] base, retExp, mmuExp;
      logic [1:0] syndExp;
      dcs_act_t a;
      retExp = 32'h0;
      mmuExp = 32'h0;
      syndExp = DCS_SYND_NONE;
      do_reset();
      rdc(DCS_OFF_CTRL, {30'h0, DCS_CTRL_RST}, "ctrl");
      rdc(DCS_OFF_STATUS, 32'h0, "status");
      for (int r = 0; r < 19; r++) begin
         base = 32'h100 * (r + 1);
         for (int k = 0; k < rows[r].n; k++)
            // idle gaps on every third row; the rest run back to back
            dcs_pipe_model_inst.issue(mk(rows[r].op[k], base + 4 * k),
                                      (r % 3 == 1) ? 1 : 0, a);
         dcs_pipe_model_inst.idle();
         chk("act", {24'h0, rows[r].act & rows[r].msk},
             {24'h0, a & rows[r].msk});
         if (rows[r].ro != 8'hff) retExp = base + rows[r].ro;
         if (rows[r].act[4])
            syndExp = rows[r].act[7] ? DCS_SYND_TLB : DCS_SYND_STOR;
         if (rows[r].act[3]) mmuExp = base;
         rdc(DCS_OFF_STATUS, {24'h0, rows[r].st}, "status");
         rdc(DCS_OFF_RETDBG, retExp, "retdbg");
         rdc(DCS_OFF_SYND, {30'h0, syndExp}, "synd");
         rdc(DCS_OFF_MMUA, mmuExp, "mmua");
         irq(rows[r].st[1:0] != 2'h0);
         wr(DCS_OFF_STATUS, 32'h47);
      end
      // return goes to the critical pair with the debug set off
      wr(DCS_OFF_CTRL, 32'h2);
      dcs_pipe_model_inst.issue(mk(LS|D1, 32'h2000), 0, a);
      dcs_pipe_model_inst.idle();
      rdc(DCS_OFF_RETCRIT, 32'h2004, "retcrit");
      rdc(DCS_OFF_RETDBG, retExp, "retdbg");
      wr(DCS_OFF_STATUS, 32'h47);
      // record with debug interrupts off marks it imprecise
      wr(DCS_OFF_CTRL, 32'h1);
      dcs_pipe_model_inst.issue(mk(LS|D2, 32'h3000), 0, a);
      dcs_pipe_model_inst.idle();
      rdc(DCS_OFF_STATUS, 32'h06, "status");
      irq(1'b0);
      wr(DCS_OFF_CTRL, 32'h3);
      irq(1'b1);
      wr(DCS_OFF_STATUS, 32'h47);
      irq(1'b0);
      // read-only and unmapped places
      wr(DCS_OFF_RETDBG, 32'hffffffff);
      rdc(DCS_OFF_RETDBG, 32'h3004, "retdbg");
      rdc(8'h18, 32'h0, "unmapped");
      // second reset in mid-run
      do_reset();
      rdc(DCS_OFF_CTRL, {30'h0, DCS_CTRL_RST}, "ctrl");
      rdc(DCS_OFF_RETDBG, 32'h0, "retdbg");
      rdc(DCS_OFF_SYND, 32'h0, "synd");
      summarize();
   end
endmodule
